// file: common/scs_pkg.sv
package scs_pkg;

    // ***************************************
    // register byte addresses
    // ***************************************
    localparam logic [4:0] ADDR_CTRL = 5'h00;
    localparam logic [4:0] ADDR_FLAGS = 5'h04;
    localparam logic [4:0] ADDR_ENABLE = 5'h08;
    localparam logic [4:0] ADDR_TXDATA = 5'h0c;
    localparam logic [4:0] ADDR_RXDATA = 5'h10;
    localparam logic [4:0] ADDR_INFO = 5'h14;
    localparam logic [4:0] ADDR_BAUD = 5'h18;
    localparam logic [4:0] ADDR_TCOUNT = 5'h1c;

    // ***************************************
    // reset values and field positions
    // ***************************************
    localparam logic [16:0] CTRL_RESET = 17'h00010;
    localparam logic [10:0] ENABLE_RESET = 11'h000;
    localparam logic [8:0] FLAGS_RESET = 9'h000;
    localparam logic [7:0] BAUD_RESET = 8'h00;
    localparam int FL_SEL_FAULT = 8;
    localparam int FL_SHIFT_EMPTY = 7;
    localparam int FL_COUNT_ZERO = 6;
    localparam int FL_SEL_START = 5;
    localparam int FL_SEL_END = 4;
    localparam int FL_RX_OVER = 2;
    localparam int FL_TX_UNDER = 1;
    localparam int EN_RX_DATA = 9;
    localparam int EN_TX_SPACE = 10;
    localparam logic [8:0] FLAG_MASK = 9'h1f6;

    // ***************************************
    // queues and answers
    // ***************************************
    localparam int QUEUE_DEPTH = 4;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // control register fields, lsb last
    typedef struct packed {
        logic [2:0] width_sel;
        logic module_status_enable;
        logic sleep_clock_runs;
        logic pin_remap;
        logic sdo_latch;
        logic sdo_dir_input;
        logic transmit_required;
        logic receive_keep_enable;
        logic select_force_active;
        logic select_polarity;
        logic clock_edge_sel;
        logic clock_polarity_sel;
        logic host_mode;
        logic enable;
    } scs_ctrl_type;

    // host shifter states
    typedef enum logic [1:0] {
        H_IDLE = 2'b00,
        H_RUN = 2'b01,
        H_TAIL = 2'b10
    } scs_host_state_type;

endpackage : scs_pkg

// file: logic/scs_spi_client.sv
// Our own choices: the register offsets and register access over AXI4-Lite.
module scs_spi_client (
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    input wire logic i_clk_en,
    input wire logic [4:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [4:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    input wire logic i_sck,
    input wire logic i_ss,
    input wire logic i_sdi,
    input wire logic i_sleep,
    output logic o_sdo,
    output logic o_sdo_oe_n,
    output logic o_sck,
    output logic o_sck_oe_n,
    output logic o_host_sel_n,
    output logic o_rx_data_pending,
    output logic o_tx_space_pending,
    output logic o_status_summary,
    output logic o_status_irq,
    output logic o_wake
);
    import scs_pkg::*;

    // *******************************************************
    // registers and state
    // *******************************************************
    logic [16:0] ctrl_q;
    logic [10:0] enable_q;
    logic [8:0] flags_q, flags_d, flag_set;
    logic [7:0] baud_q, baud_cnt_q, last_rx_q, tx_sh_q, rx_sh_q;
    logic [10:0] tcount_q;
    logic [7:0] rxq [QUEUE_DEPTH];
    logic [7:0] txq [QUEUE_DEPTH];
    logic [1:0] rx_wp_q, rx_rp_q, tx_wp_q, tx_rp_q;
    logic [2:0] rx_cnt_q, tx_cnt_q, bit_cnt_q;
    logic [3:0] h_edges_q;
    logic from_q_q, host_sck_q, eff_sel_q, sdo_q, sdo_oe_n_q, sck_out_q;
    logic [2:0] sck_sy_q;
    logic [1:0] ss_sy_q, sdi_sy_q;
    scs_host_state_type h_state_q;
    scs_ctrl_type cfg;
    assign cfg = scs_ctrl_type'(ctrl_q);

    // merge written bytes into a register image
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    // true when the address names a mapped register
    function automatic logic mapped(input logic [4:0] a);
        return a[1:0] == 2'h0;
    endfunction : mapped

    // *******************************************************
    // pin synchronisers
    // *******************************************************
    // pins come from the host's domain; sck gets a third stage for edges
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sck_sy_q <= 3'h0;
            ss_sy_q <= 2'h3;
            sdi_sy_q <= 2'h0;
        end else if (i_clk_en) begin
            sck_sy_q <= {sck_sy_q[1:0], i_sck};
            ss_sy_q <= {ss_sy_q[0], i_ss};
            sdi_sy_q <= {sdi_sy_q[0], i_sdi};
        end
    end

    // *******************************************************
    // select and clock decode
    // *******************************************************
    logic sck_s, sck_old, ss_s, sdi_s, pin_act, eff_sel, client, host;
    logic client_act, sck_rise, sck_fall, lead, trail;
    assign sck_s = sck_sy_q[1];
    assign sck_old = sck_sy_q[2];
    assign ss_s = ss_sy_q[1];
    assign sdi_s = sdi_sy_q[1];
    assign host = cfg.enable & cfg.host_mode;
    assign client = cfg.enable & ~cfg.host_mode;
    assign pin_act = cfg.select_polarity ? ~ss_s : ss_s;
    assign eff_sel = cfg.select_force_active | pin_act;
    assign client_act = client & eff_sel;
    assign sck_rise = sck_s & ~sck_old;
    assign sck_fall = ~sck_s & sck_old;
    // idle level from polarity; leading edge leaves idle
    assign lead = cfg.clock_polarity_sel ? sck_fall : sck_rise;
    assign trail = cfg.clock_polarity_sel ? sck_rise : sck_fall;

    // *******************************************************
    // host clock generation
    // *******************************************************
    logic h_tick, h_lead, h_trail, h_start_ok, h_run, samp_ev, chg_ev;
    logic [3:0] wbits;
    logic word_done, load, first_samp, sel_rise, sel_fall;
    assign wbits = (cfg.width_sel == 3'h0) ? 4'h8 : {1'b0, cfg.width_sel};
    assign h_run = h_state_q == H_RUN;
    assign h_tick = (h_state_q != H_IDLE) & (baud_cnt_q == 8'h00);
    assign h_lead = h_run & h_tick & (host_sck_q == cfg.clock_polarity_sel);
    assign h_trail = h_run & h_tick & (host_sck_q != cfg.clock_polarity_sel);
    // start needs data under transmit_required and room under keep
    assign h_start_ok = host & (~i_sleep | cfg.sleep_clock_runs)
        & (cfg.transmit_required | cfg.receive_keep_enable)
        & (~cfg.transmit_required | (tx_cnt_q != 3'h0))
        & (~cfg.receive_keep_enable | (rx_cnt_q != 3'(QUEUE_DEPTH)));

    // sample edge and change edge, either from the pin or the timer
    assign samp_ev = cfg.clock_edge_sel ? (client_act & lead) | h_lead
                                        : (client_act & trail) | h_trail;
    assign chg_ev = cfg.clock_edge_sel ? (client_act & trail) | h_trail
                                       : (client_act & lead) | h_lead;
    assign word_done = samp_ev & ({1'b0, bit_cnt_q} == wbits - 4'h1);
    assign first_samp = samp_ev & (bit_cnt_q == 3'h0);
    assign sel_rise = eff_sel & ~eff_sel_q;
    assign sel_fall = ~eff_sel & eff_sel_q;
    assign load = (client & (sel_rise | word_done))
        | (h_state_q == H_IDLE & h_start_ok)
        | (h_state_q == H_TAIL & h_tick & h_start_ok);

    // host sequencer: run, park sck for half a baud, then decide
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            h_state_q <= H_IDLE;
            baud_cnt_q <= BAUD_RESET;
            h_edges_q <= 4'h0;
            host_sck_q <= 1'b0;
        end else if (i_clk_en) begin
            baud_cnt_q <= (h_tick | h_state_q == H_IDLE) ? baud_q
                                                         : baud_cnt_q - 8'h01;
            if (h_state_q == H_IDLE) begin
                host_sck_q <= cfg.clock_polarity_sel;
            end
            unique case (h_state_q)
                H_IDLE: begin
                    h_edges_q <= 4'h0;
                    if (h_start_ok) begin
                        h_state_q <= H_RUN;
                    end
                end
                H_RUN: begin
                    if (h_tick) begin
                        host_sck_q <= ~host_sck_q;
                        h_edges_q <= h_edges_q + 4'h1;
                        if (h_edges_q == {wbits[2:0], 1'b0} - 4'h1) begin
                            h_state_q <= H_TAIL;
                        end
                    end
                end
                H_TAIL: begin
                    h_edges_q <= 4'h0;
                    if (h_tick) begin
                        h_state_q <= h_start_ok ? H_RUN : H_IDLE;
                    end
                end
                default: begin
                    h_state_q <= H_IDLE;
                end
            endcase
        end
    end

    // *******************************************************
    // shift registers
    // *******************************************************
    logic [7:0] rx_word, tx_head, rx_head;
    logic tx_empty, rx_full, rx_push, rx_pop, tx_push, tx_pop;
    assign rx_word = {rx_sh_q[6:0], sdi_s} & (8'hff >> (4'h8 - wbits));
    assign tx_empty = tx_cnt_q == 3'h0;
    assign rx_full = rx_cnt_q == 3'(QUEUE_DEPTH);
    assign tx_head = txq[tx_rp_q];
    assign rx_head = rxq[rx_rp_q];

    // the bit counter restarts whenever the client is deselected
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            bit_cnt_q <= 3'h0;
            rx_sh_q <= 8'h00;
            tx_sh_q <= 8'h00;
            last_rx_q <= 8'h00;
            from_q_q <= 1'b0;
            eff_sel_q <= 1'b0;
        end else if (i_clk_en) begin
            eff_sel_q <= eff_sel;
            if (samp_ev) begin
                rx_sh_q <= {rx_sh_q[6:0], sdi_s};
                bit_cnt_q <= word_done ? 3'h0 : bit_cnt_q + 3'h1;
            end else if (client & ~eff_sel) begin
                bit_cnt_q <= 3'h0;
            end
            if (word_done) begin
                last_rx_q <= rx_word;
            end
            if (load) begin
                // empty queue falls back to the last received word
                // at a word end the word just taken is the newest one
                tx_sh_q <= (tx_empty ? (word_done ? rx_word : last_rx_q)
                    : tx_head) << (4'h8 - wbits);
                from_q_q <= ~tx_empty;
            end else if (chg_ev & (bit_cnt_q != 3'h0)) begin
                tx_sh_q <= {tx_sh_q[6:0], 1'b0};
            end
        end
    end

    // *******************************************************
    // queues
    // *******************************************************
    logic rd_rx, wr_tx;
    assign rx_push = word_done & cfg.receive_keep_enable & ~rx_full;
    assign rx_pop = rd_rx & (rx_cnt_q != 3'h0);
    assign tx_push = wr_tx & (tx_cnt_q != 3'(QUEUE_DEPTH));
    // only transmit_required consumes the word, at its first sample edge
    assign tx_pop = first_samp & from_q_q & cfg.transmit_required;

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rx_wp_q <= 2'h0;
            rx_rp_q <= 2'h0;
            rx_cnt_q <= 3'h0;
            tx_wp_q <= 2'h0;
            tx_rp_q <= 2'h0;
            tx_cnt_q <= 3'h0;
        end else if (i_clk_en) begin
            rx_wp_q <= rx_wp_q + {1'b0, rx_push};
            rx_rp_q <= rx_rp_q + {1'b0, rx_pop};
            rx_cnt_q <= rx_cnt_q + {2'h0, rx_push} - {2'h0, rx_pop};
            tx_wp_q <= tx_wp_q + {1'b0, tx_push};
            tx_rp_q <= tx_rp_q + {1'b0, tx_pop};
            tx_cnt_q <= tx_cnt_q + {2'h0, tx_push} - {2'h0, tx_pop};
        end
    end

    // queue storage carries no reset
    always_ff @(posedge i_core_clk) begin
        if (i_clk_en & rx_push) begin
            rxq[rx_wp_q] <= rx_word;
        end
        if (i_clk_en & tx_push) begin
            txq[tx_wp_q] <= i_wdata[7:0];
        end
    end

    // *******************************************************
    // status flags
    // *******************************************************
    logic sel_fault_ev, tc_one;
    assign tc_one = tcount_q == 11'h001;
    assign sel_fault_ev = client & sel_fall & (bit_cnt_q != 3'h0);
    always_comb begin
        flag_set = 9'h000;
        flag_set[FL_SEL_FAULT] = sel_fault_ev;
        flag_set[FL_SHIFT_EMPTY] = host & h_state_q == H_TAIL & h_tick
            & ~h_start_ok;
        flag_set[FL_COUNT_ZERO] = word_done & tc_one;
        flag_set[FL_SEL_START] = cfg.enable & sel_rise;
        flag_set[FL_SEL_END] = cfg.enable & sel_fall;
        flag_set[FL_RX_OVER] = client & word_done
            & cfg.receive_keep_enable & rx_full;
        flag_set[FL_TX_UNDER] = client & first_samp & ~from_q_q
            & cfg.transmit_required;
    end

    // *******************************************************
    // AXI4-Lite slave
    // *******************************************************
    logic aw_have_q, w_have_q, do_wr, do_rd;
    logic [4:0] awaddr_q;
    logic [31:0] wdata_q, rdata_d;
    logic [3:0] wstrb_q;
    logic [31:0] ctrl_m, en_m, baud_m, tc_m;
    assign o_awready = ~aw_have_q & ~o_bvalid;
    assign o_wready = ~w_have_q & ~o_bvalid;
    assign o_arready = ~o_rvalid;
    assign do_wr = aw_have_q & w_have_q & ~o_bvalid;
    assign do_rd = i_arvalid & o_arready;
    assign wr_tx = do_wr & (awaddr_q == ADDR_TXDATA) & wstrb_q[0];
    assign rd_rx = do_rd & (i_araddr == ADDR_RXDATA);
    assign ctrl_m = merge({15'h0, ctrl_q}, wdata_q, wstrb_q);
    assign en_m = merge({21'h0, enable_q}, wdata_q, wstrb_q);
    assign baud_m = merge({24'h0, baud_q}, wdata_q, wstrb_q);
    assign tc_m = merge({21'h0, tcount_q}, wdata_q, wstrb_q);

    // read mux; unmapped words read zero with an error answer
    always_comb begin
        unique case (i_araddr)
            ADDR_CTRL: rdata_d = {15'h0, ctrl_q};
            ADDR_FLAGS: rdata_d = {23'h0, flags_q};
            ADDR_ENABLE: rdata_d = {21'h0, enable_q};
            ADDR_RXDATA: rdata_d = {24'h0, rx_head};
            ADDR_INFO: rdata_d = {20'h0, o_status_summary,
                o_tx_space_pending, o_rx_data_pending,
                h_state_q != H_IDLE | bit_cnt_q != 3'h0,
                1'b0, tx_cnt_q, 1'b0, rx_cnt_q};
            ADDR_BAUD: rdata_d = {24'h0, baud_q};
            ADDR_TCOUNT: rdata_d = {21'h0, tcount_q};
            default: rdata_d = 32'h0000_0000;
        endcase
    end

    // channel bookkeeping; address and data may come in either order
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= 5'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            o_bvalid <= 1'b0;
            o_bresp <= RESP_OKAY;
            o_rvalid <= 1'b0;
            o_rresp <= RESP_OKAY;
            o_rdata <= 32'h0000_0000;
        end else if (i_clk_en) begin
            if (i_awvalid & o_awready) begin
                aw_have_q <= 1'b1;
                awaddr_q <= i_awaddr;
            end
            if (i_wvalid & o_wready) begin
                w_have_q <= 1'b1;
                wdata_q <= i_wdata;
                wstrb_q <= i_wstrb;
            end
            if (do_wr) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                o_bvalid <= 1'b1;
                o_bresp <= (mapped(awaddr_q) & awaddr_q != ADDR_INFO
                    & awaddr_q != ADDR_RXDATA) ? RESP_OKAY : RESP_SLVERR;
            end else if (i_bready) begin
                o_bvalid <= 1'b0;
            end
            if (do_rd) begin
                o_rvalid <= 1'b1;
                o_rdata <= rdata_d;
                o_rresp <= (mapped(i_araddr) & i_araddr != ADDR_TXDATA)
                    ? RESP_OKAY : RESP_SLVERR;
            end else if (i_rready) begin
                o_rvalid <= 1'b0;
            end
        end
    end

    // *******************************************************
    // software registers
    // *******************************************************
    logic wr_flags;
    assign wr_flags = do_wr & (awaddr_q == ADDR_FLAGS) & wstrb_q[0];
    // a written zero clears; a set in the same cycle wins
    always_comb begin
        flags_d = flags_q;
        if (wr_flags) begin
            flags_d = flags_q & {wstrb_q[1] ? wdata_q[8] : flags_q[8],
                                 wdata_q[7:0]};
        end
        flags_d = (flags_d | flag_set) & FLAG_MASK;
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ctrl_q <= CTRL_RESET;
            enable_q <= ENABLE_RESET;
            flags_q <= FLAGS_RESET;
            baud_q <= BAUD_RESET;
            tcount_q <= 11'h000;
        end else if (i_clk_en) begin
            flags_q <= flags_d;
            if (do_wr & awaddr_q == ADDR_CTRL) begin
                ctrl_q <= ctrl_m[16:0];
            end
            if (do_wr & awaddr_q == ADDR_ENABLE) begin
                enable_q <= en_m[10:0];
            end
            if (do_wr & awaddr_q == ADDR_BAUD) begin
                baud_q <= baud_m[7:0];
            end
            if (do_wr & awaddr_q == ADDR_TCOUNT) begin
                tcount_q <= tc_m[10:0];
            end else if (word_done & tcount_q != 11'h000) begin
                tcount_q <= tcount_q - 11'h001;
            end
        end
    end

    // *******************************************************
    // pins and summary outputs
    // *******************************************************
    // tristate leaves the pin to its pull; latch drive when selected off
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sdo_q <= 1'b0;
            sdo_oe_n_q <= 1'b1;
            sck_out_q <= 1'b0;
        end else if (i_clk_en) begin
            if (host | client_act) begin
                sdo_q <= tx_sh_q[7];
                sdo_oe_n_q <= ~host & cfg.sdo_dir_input
                    & ~cfg.transmit_required;
            end else begin
                sdo_q <= cfg.sdo_latch;
                sdo_oe_n_q <= cfg.sdo_dir_input;
            end
            sck_out_q <= host ? host_sck_q : sck_s;
        end
    end

    logic rx_any_en, tx_any_en;
    assign o_sdo = sdo_q;
    assign o_sdo_oe_n = sdo_oe_n_q;
    assign o_sck = sck_out_q;
    // client drives the chained clock only when the pins are split
    assign o_sck_oe_n = ~(host | (client & cfg.pin_remap));
    assign o_host_sel_n = ~(host & h_state_q != H_IDLE);
    assign o_rx_data_pending = rx_cnt_q != 3'h0;
    assign o_tx_space_pending = tx_cnt_q != 3'(QUEUE_DEPTH);
    assign o_status_summary = |(flags_q[7:0] & enable_q[7:0]);
    assign o_status_irq = o_status_summary & cfg.module_status_enable;
    assign rx_any_en = o_rx_data_pending & enable_q[EN_RX_DATA];
    assign tx_any_en = o_tx_space_pending & enable_q[EN_TX_SPACE];
    // only enabled sources wake a sleeping device
    assign o_wake = i_sleep & (o_status_irq | rx_any_en | tx_any_en);

endmodule : scs_spi_client

// file: testbench/scs_spi_client_sva.sv
// ***************************************
// bus handshake and status pin checks
// ***************************************
module scs_spi_client_sva (
    input wire logic i_core_clk, i_reset_n, i_sleep, i_bready, i_rready,
    input wire logic o_bvalid, o_rvalid, o_wake, o_status_irq,
    input wire logic o_status_summary, o_rx_data_pending,
    input wire logic o_tx_space_pending
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_reset_n);
    sequence s_b_done; o_bvalid && i_bready; endsequence
    property p_wake; o_wake |-> i_sleep; endproperty
    a_wake: assert property (p_wake) else $error("wake awake");
    property p_irq; o_status_irq |-> o_status_summary; endproperty
    a_irq: assert property (p_irq) else $error("irq no sum");
    property p_slp; o_status_irq && i_sleep |-> o_wake; endproperty
    a_slp: assert property (p_slp) else $error("no wake");
    // the rx queue only empties, and the tx queue only fills, through a bus transfer
    property p_rxf; $fell(o_rx_data_pending) |-> $rose(o_rvalid); endproperty
    a_rxf: assert property (p_rxf) else $error("rx fell");
    property p_txf; $fell(o_tx_space_pending) |-> $rose(o_bvalid); endproperty
    a_txf: assert property (p_txf) else $error("tx fell");
    property p_bh; o_bvalid && !i_bready |=> o_bvalid; endproperty
    a_bh: assert property (p_bh) else $error("b drop");
    property p_rh; o_rvalid && !i_rready |=> o_rvalid; endproperty
    a_rh: assert property (p_rh) else $error("r drop");
    property p_bc; s_b_done |=> !o_bvalid; endproperty
    a_bc: assert property (p_bc) else $error("b stuck");
endmodule : scs_spi_client_sva
bind scs_spi_client scs_spi_client_sva i_sva (.i_core_clk, .i_reset_n,
    .i_sleep, .i_bready, .i_rready, .o_bvalid, .o_rvalid, .o_wake,
    .o_status_irq, .o_status_summary, .o_rx_data_pending,
    .o_tx_space_pending);

// file: testbench/scs_host_model.sv
// ***************************************
// serial host, idle-low clock, sample lead
// ***************************************
module scs_host_model (
    output logic o_sck,
    output logic o_ss_n,
    output logic o_sdi,
    input wire logic i_sdo
);
    timeunit 1ns;
    timeprecision 1ps;
    // clock stands low outside frames
    initial begin
        o_sck = 1'b0;
        o_ss_n = 1'b1;
        o_sdi = 1'b0;
    end
    // released data line shows inverse, not a stale bit
    task automatic sel(input logic act);
        #1 o_ss_n = !act;
        if (!act) o_sdi = !o_sdi;
        #64;
    endtask : sel
    // msb first, 64 ns bit time
    task automatic shift(input logic [7:0] tx, input int n,
                         output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - n; i--) begin
            o_sdi = tx[i];
            #32 o_sck = 1'b1;
            rx[i] = i_sdo;
            #32 o_sck = 1'b0;
        end
    endtask : shift
endmodule : scs_host_model

// file: testbench/scs_spi_client_test.sv
module scs_spi_client_test;
    timeunit 1ns;
    timeprecision 1ps;
    import scs_pkg::*;
    logic i_core_clk = 0, i_reset_n = 0, i_clk_en = 1, i_sleep = 0;
    logic i_awvalid = 0, i_wvalid = 0, i_bready = 0, i_arvalid = 0;
    logic i_rready = 0, i_sck, i_ss, i_sdi, o_awready, o_wready, o_bvalid;
    logic o_arready, o_rvalid, o_sdo, o_sdo_oe_n, o_sck, o_sck_oe_n;
    logic o_host_sel_n, o_rx_data_pending, o_tx_space_pending, o_wake;
    logic o_status_summary, o_status_irq;
    logic [4:0] i_awaddr = 5'h00, i_araddr = 5'h00;
    logic [31:0] i_wdata = 32'h0, o_rdata, ctl = 32'h10d9;
    logic [3:0] i_wstrb = 4'hf;
    logic [1:0] o_bresp, o_rresp;
    logic [7:0] rx;
    int err_count = 0, n_compared = 0, cyc = 0;
    scs_spi_client i_dut (.i_core_clk, .i_reset_n, .i_clk_en, .i_awaddr,
        .i_awvalid, .o_awready, .i_wdata, .i_wstrb, .i_wvalid, .o_wready,
        .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready,
        .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_sck, .i_ss, .i_sdi,
        .i_sleep, .o_sdo, .o_sdo_oe_n, .o_sck, .o_sck_oe_n, .o_host_sel_n,
        .o_rx_data_pending, .o_tx_space_pending, .o_status_summary,
        .o_status_irq, .o_wake);
    scs_host_model i_host (.o_sck(i_sck), .o_ss_n(i_ss), .o_sdi(i_sdi),
        .i_sdo(o_sdo));
    // 200 MHz core clock; hang guard
    always #2.5 i_core_clk = ~i_core_clk;
    always @(posedge i_core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("errors %0d compares %0d", err_count, n_compared);
        if (err_count == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    // address and data offered together, each dropped once taken
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge i_core_clk);
        {i_awaddr, i_wdata, i_awvalid, i_wvalid, i_bready} <= {a, d, 3'h7};
        do begin
            @(posedge i_core_clk);
            if (o_awready) i_awvalid <= 1'b0;
            if (o_wready) i_wvalid <= 1'b0;
        end while (!o_bvalid);
        i_bready <= 1'b0;
        chk(32'(o_bresp), 32'(RESP_OKAY));
    endtask : wr
    task automatic rd(input logic [4:0] a, input logic [31:0] e,
                      input logic [1:0] r);
        @(posedge i_core_clk);
        {i_araddr, i_arvalid, i_rready} <= {a, 2'h3};
        do begin
            @(posedge i_core_clk);
            if (o_arready) i_arvalid <= 1'b0;
        end while (!o_rvalid);
        i_rready <= 1'b0;
        chk(o_rdata, e);
        chk(32'(o_rresp), 32'(r));
    endtask : rd
    // ***************************************
    // main sequence
    // ***************************************
    initial begin
        repeat (6) @(posedge i_core_clk);
        i_reset_n <= 1'b1;
        rd(ADDR_CTRL, 32'(CTRL_RESET), RESP_OKAY);
        rd(ADDR_FLAGS, 32'(FLAGS_RESET), RESP_OKAY);
        rd(5'h02, 32'h0, RESP_SLVERR);
        wr(ADDR_ENABLE, 32'h7f6);
        wr(ADDR_CTRL, ctl);
        wr(ADDR_TXDATA, 32'ha5);
        i_host.sel(1'b1);
        i_host.shift(8'h3c, 8, rx);
        i_host.sel(1'b0);
        chk(32'(rx), 32'ha5);
        chk(32'(o_rx_data_pending), 32'h1);
        rd(ADDR_RXDATA, 32'h3c, RESP_OKAY);
        rd(ADDR_FLAGS, 32'h30, RESP_OKAY);
        wr(ADDR_FLAGS, 32'h0);
        // empty tx queue echoes last word; fifth word overflows
        i_host.sel(1'b1);
        for (int i = 0; i < 5; i++) begin
            i_host.shift(8'(8'h40 + i), 8, rx);
            chk(32'(rx), i == 0 ? 32'h3c : 32'h3f + i);
        end
        i_host.sel(1'b0);
        rd(ADDR_FLAGS, 32'h36, RESP_OKAY);
        chk(32'(o_status_irq), 32'h1);
        i_sleep <= 1'b1;
        @(posedge i_core_clk);
        chk(32'(o_wake), 32'h1);
        i_sleep <= 1'b0;
        wr(ADDR_FLAGS, 32'h0);
        chk(32'(o_status_summary), 32'h0);
        for (int i = 0; i < 4; i++) rd(ADDR_RXDATA, 32'h40 + i, RESP_OKAY);
        chk(32'(o_rx_data_pending), 32'h0);
        // half word then deselect
        i_host.sel(1'b1);
        i_host.shift(8'h00, 4, rx);
        i_host.sel(1'b0);
        rd(ADDR_FLAGS, 32'h132, RESP_OKAY);
        i_wstrb <= 4'h1;
        wr(ADDR_FLAGS, 32'h0);
        rd(ADDR_FLAGS, 32'h100, RESP_OKAY);
        i_wstrb <= 4'hf;
        wr(ADDR_FLAGS, 32'h0);
        wr(ADDR_CTRL, ctl & ~32'h10);
        rd(ADDR_FLAGS, 32'h20, RESP_OKAY);
        wr(ADDR_CTRL, ctl | 32'h120);
        @(posedge i_core_clk);
        chk(32'(o_sdo_oe_n), 32'h0);
        wr(ADDR_CTRL, ctl);
        rd(ADDR_FLAGS, 32'h30, RESP_OKAY);
        wr(ADDR_CTRL, ctl | 32'h100);
        @(posedge i_core_clk);
        chk(32'(o_sdo_oe_n), 32'h1);
        wr(ADDR_CTRL, 32'h1611);
        @(posedge i_core_clk);
        chk(32'(o_sdo), 32'h1);
        chk(32'(o_sck_oe_n), 32'h0);
        for (int i = 0; i < 4; i++) wr(ADDR_TXDATA, 32'h11);
        chk(32'(o_tx_space_pending), 32'h0);
        wr(ADDR_FLAGS, 32'h0);
        i_clk_en <= 1'b0;
        i_host.sel(1'b1);
        i_host.sel(1'b0);
        @(posedge i_core_clk);
        i_clk_en <= 1'b1;
        rd(ADDR_FLAGS, 32'h0, RESP_OKAY);
        wr(ADDR_TCOUNT, 32'h4);
        wr(ADDR_CTRL, 32'h1093);
        @(posedge i_core_clk);
        chk(32'(o_host_sel_n), 32'h0);
        repeat (150) @(posedge i_core_clk);
        rd(ADDR_FLAGS, 32'hc0, RESP_OKAY);
        give_verdict();
    end
endmodule : scs_spi_client_test
